// *** design/two_point_pkg.sv ***
package two_point_pkg;

  // Temperature word: signed, 0.01 K per step
  localparam int TEMP_W = 16;
  // Evaluation interval of the two-point decision
  localparam int EVAL_PERIOD_S = 30;
  localparam longint CLK_HZ = 20000000;
  localparam longint EVAL_CYCLES = longint'(EVAL_PERIOD_S) * CLK_HZ;
  localparam int EVAL_CNT_W = 30;
  // Reset values
  localparam logic RST_STAGE = 1'b0;
  localparam logic RST_INVERT = 1'b0;

  typedef enum logic [1:0] {
    MODE_HEAT_ONLY,
    MODE_COOL_ONLY,
    MODE_MIXED_AUTO,
    MODE_MIXED_OBJ
  } op_mode_t;

  // Setpoints and hysteresis limits of one stage pair
  typedef struct packed {
    logic signed [TEMP_W-1:0] heat_set;
    logic signed [TEMP_W-1:0] cool_set;
    logic signed [TEMP_W-1:0] heat_lo;
    logic signed [TEMP_W-1:0] heat_hi;
    logic signed [TEMP_W-1:0] cool_lo;
    logic signed [TEMP_W-1:0] cool_hi;
  } limits_t;

  // Switching state of both stages
  typedef struct packed {
    logic heat;
    logic cool;
  } stage_t;

endpackage : two_point_pkg

// *** design/two_point_hysteresis_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module two_point_hysteresis_control
  import two_point_pkg::*;
#(
  parameter longint EVAL_CYCLES_P = EVAL_CYCLES
) (
  input wire logic clk_in, // System clock, 20 MHz
  input wire logic sys_rst_in, // Async reset, active high
  input wire logic clk_en_in, // Freezes all state when low
  input wire logic signed [TEMP_W-1:0] temp_in, // Room temperature
  input wire op_mode_t mode_in, // Operating mode
  input wire logic cool_sel_in, // Object changeover: 1 selects cooling
  input wire limits_t limits_in, // Basic stage setpoints and limits
  input wire logic signed [TEMP_W-1:0] stage_offset_in, // Additional stage offset
  input wire logic invert_in, // Invert command outputs, applied at each evaluation; reset loads 0
  output var stage_t basic_cmd_out, // Basic stage commands
  output var stage_t extra_cmd_out, // Additional stage commands
  output var logic heat_msg_out, // Heating message flag
  output var logic cool_msg_out, // Cooling message flag
  output var logic eval_tick_out // Pulse at each evaluation
);

  ////////////////////////////////////////////////////////////////////////
  // Evaluation timer
  localparam logic [EVAL_CNT_W-1:0] EVAL_LAST = EVAL_CNT_W'(EVAL_CYCLES_P - 1);

  logic [EVAL_CNT_W-1:0] eval_cnt;
  logic [EVAL_CNT_W-1:0] next_eval_cnt;
  logic eval_now;

  // Free-running divider; one pulse per period
  always_comb begin
    eval_now = (eval_cnt == EVAL_LAST);
    next_eval_cnt = eval_now ? '0 : eval_cnt + 1'b1;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      eval_cnt <= '0;
    end else if (clk_en_in) begin
      eval_cnt <= next_eval_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-stage two-point decision, index 0 basic, 1 additional
  stage_t state [2];
  stage_t next_state [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_stage
      limits_t lim;
      logic signed [TEMP_W-1:0] off;
      always_comb begin
        off = (g == 1) ? stage_offset_in : '0;
        lim.heat_set = limits_in.heat_set - off;
        lim.heat_lo = limits_in.heat_lo - off;
        lim.heat_hi = limits_in.heat_hi - off;
        lim.cool_set = limits_in.cool_set + off;
        lim.cool_lo = limits_in.cool_lo + off;
        lim.cool_hi = limits_in.cool_hi + off;
      end

      // Next switching state, only used at eval instants
      always_comb begin
        next_state[g] = state[g];
        case (mode_in)
          MODE_HEAT_ONLY: begin
            next_state[g].cool = 1'b0;
            if (temp_in < lim.heat_lo) next_state[g].heat = 1'b1;
            else if (temp_in > lim.heat_hi) next_state[g].heat = 1'b0;
          end
          MODE_COOL_ONLY: begin
            next_state[g].heat = 1'b0;
            if (temp_in > lim.cool_hi) next_state[g].cool = 1'b1;
            else if (temp_in < lim.cool_lo) next_state[g].cool = 1'b0;
          end
          // setpoints end the request; heat_hi, cool_lo unused
          MODE_MIXED_AUTO: begin
            if (temp_in < lim.heat_lo) next_state[g].heat = 1'b1;
            else if (temp_in > lim.heat_set) next_state[g].heat = 1'b0;
            if (temp_in > lim.cool_hi) next_state[g].cool = 1'b1;
            else if (temp_in < lim.cool_set) next_state[g].cool = 1'b0;
          end
          // both limits per mode, deadband not consulted
          MODE_MIXED_OBJ: begin
            if (cool_sel_in) begin
              next_state[g].heat = 1'b0;
              if (temp_in > lim.cool_hi) next_state[g].cool = 1'b1;
              else if (temp_in < lim.cool_lo) next_state[g].cool = 1'b0;
            end else begin
              next_state[g].cool = 1'b0;
              if (temp_in < lim.heat_lo) next_state[g].heat = 1'b1;
              else if (temp_in > lim.heat_hi) next_state[g].heat = 1'b0;
            end
          end
          default: next_state[g] = '0;
        endcase
      end

      always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          state[g] <= '{heat: RST_STAGE, cool: RST_STAGE};
        end else if (clk_en_in && eval_now) begin
          state[g] <= next_state[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all registered
  stage_t next_basic_cmd;
  stage_t next_extra_cmd;
  logic next_heat_msg;
  logic next_cool_msg;
  logic heat_mode_ok;
  logic cool_mode_ok;

  // Message flags have no hysteresis, judged at the same instants
  always_comb begin
    heat_mode_ok = (mode_in == MODE_HEAT_ONLY) || (mode_in == MODE_MIXED_AUTO) ||
                   ((mode_in == MODE_MIXED_OBJ) && !cool_sel_in);
    cool_mode_ok = (mode_in == MODE_COOL_ONLY) || (mode_in == MODE_MIXED_AUTO) ||
                   ((mode_in == MODE_MIXED_OBJ) && cool_sel_in);
    next_basic_cmd.heat = next_state[0].heat ^ invert_in;
    next_basic_cmd.cool = next_state[0].cool ^ invert_in;
    next_extra_cmd.heat = next_state[1].heat ^ invert_in;
    next_extra_cmd.cool = next_state[1].cool ^ invert_in;
    next_heat_msg = heat_mode_ok && (temp_in < limits_in.heat_set);
    next_cool_msg = cool_mode_ok && (temp_in > limits_in.cool_set);
  end

  // commands and flags at eval instants, eval_tick_out every enabled cycle
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      basic_cmd_out <= '{heat: RST_INVERT, cool: RST_INVERT};
      extra_cmd_out <= '{heat: RST_INVERT, cool: RST_INVERT};
      heat_msg_out <= 1'b0;
      cool_msg_out <= 1'b0;
      eval_tick_out <= 1'b0;
    end else if (clk_en_in) begin
      eval_tick_out <= eval_now;
      if (eval_now) begin
        basic_cmd_out <= next_basic_cmd;
        extra_cmd_out <= next_extra_cmd;
        heat_msg_out <= next_heat_msg;
        cool_msg_out <= next_cool_msg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  logic past_valid;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) past_valid <= 1'b0;
    else past_valid <= 1'b1;
  end

  // Enabled cycles since the last pulse seen on eval_tick_out; counted
  // apart from the divider so that a slip shows up as a spacing error
  logic [EVAL_CNT_W-1:0] tick_gap;
  logic [EVAL_CNT_W-1:0] next_tick_gap;
  logic tick_seen;
  logic next_tick_seen;

  always_comb begin
    next_tick_gap = eval_tick_out ? '0 : tick_gap + 1'b1;
    next_tick_seen = tick_seen || eval_tick_out;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tick_gap <= '0;
      tick_seen <= 1'b0;
    end else if (clk_en_in) begin
      tick_gap <= next_tick_gap;
      tick_seen <= next_tick_seen;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in || !past_valid);

  // One evaluation instant with the clock enabled
  sequence s_eval;
    clk_en_in && eval_now;
  endsequence

  // An enabled cycle between evaluation instants
  sequence s_quiet;
    clk_en_in && !eval_now;
  endsequence

  // Automatic mixed mode with the basic stage inside the deadband
  sequence s_auto_dead;
    mode_in == MODE_MIXED_AUTO && temp_in > limits_in.heat_set &&
      temp_in < limits_in.cool_set;
  endsequence

  // Object heating mode inside its span, which may reach into the deadband
  sequence s_obj_heat_span;
    mode_in == MODE_MIXED_OBJ && !cool_sel_in && temp_in >= limits_in.heat_lo &&
      temp_in <= limits_in.heat_hi;
  endsequence

  // Evaluation timing and pulse
  AST_EVAL_ONLY: assert property (s_quiet |=> $stable(basic_cmd_out) && $stable(extra_cmd_out))
    else $error("command changed outside evaluation");
  AST_FROZEN: assert property (!clk_en_in |=> $stable(basic_cmd_out) && $stable(extra_cmd_out) &&
      $stable(heat_msg_out) && $stable(cool_msg_out) && $stable(eval_tick_out) && $stable(eval_cnt))
    else $error("state moved while clock disabled");
  AST_TICK_FOLLOWS: assert property (s_eval |=> eval_tick_out)
    else $error("evaluation pulse missing");
  AST_TICK_QUIET: assert property (s_quiet |=> !eval_tick_out)
    else $error("evaluation pulse without evaluation");
  AST_EVAL_SPACING: assert property (clk_en_in && tick_seen |-> eval_tick_out == (tick_gap == EVAL_LAST))
    else $error("evaluation spacing wrong");

  // Heating-only hysteresis, basic stage; hold judged on the logical state
  AST_HEAT_ON: assert property (s_eval ##0 (mode_in == MODE_HEAT_ONLY &&
      temp_in < limits_in.heat_lo) |=> basic_cmd_out.heat == !$past(invert_in))
    else $error("heating not switched on below lower limit");
  AST_HEAT_OFF: assert property (s_eval ##0 (mode_in == MODE_HEAT_ONLY &&
      temp_in > limits_in.heat_hi) |=> basic_cmd_out.heat == $past(invert_in))
    else $error("heating not switched off above upper limit");
  AST_HEAT_HOLD: assert property (s_eval ##0 (mode_in == MODE_HEAT_ONLY &&
      temp_in >= limits_in.heat_lo && temp_in <= limits_in.heat_hi) |=> $stable(state[0].heat))
    else $error("heating changed inside hysteresis");

  // Cooling-only hysteresis, basic stage
  AST_COOL_ON: assert property (s_eval ##0 (mode_in == MODE_COOL_ONLY &&
      temp_in > limits_in.cool_hi) |=> basic_cmd_out.cool == !$past(invert_in))
    else $error("cooling not switched on above upper limit");
  AST_COOL_OFF: assert property (s_eval ##0 (mode_in == MODE_COOL_ONLY &&
      temp_in < limits_in.cool_lo) |=> basic_cmd_out.cool == $past(invert_in))
    else $error("cooling not switched off below lower limit");
  AST_COOL_HOLD: assert property (s_eval ##0 (mode_in == MODE_COOL_ONLY &&
      temp_in >= limits_in.cool_lo && temp_in <= limits_in.cool_hi) |=> $stable(state[0].cool))
    else $error("cooling changed inside hysteresis");

  // Additional stage, limits shifted away from the basic ones
  AST_EXTRA_HEAT_ON: assert property (s_eval ##0 (mode_in == MODE_HEAT_ONLY &&
      temp_in < limits_in.heat_lo - stage_offset_in) |=> extra_cmd_out.heat == !$past(invert_in))
    else $error("additional heating not on below shifted limit");
  AST_EXTRA_COOL_ON: assert property (s_eval ##0 (mode_in == MODE_COOL_ONLY &&
      temp_in > limits_in.cool_hi + stage_offset_in) |=> extra_cmd_out.cool == !$past(invert_in))
    else $error("additional cooling not on above shifted limit");

  // Automatic mixed mode; setpoints end a request, heat_hi and cool_lo unused
  AST_AUTO_OFF: assert property (s_eval ##0 (mode_in == MODE_MIXED_AUTO &&
      temp_in > limits_in.heat_set) |=> basic_cmd_out.heat == $past(invert_in))
    else $error("heating not off above setpoint");
  AST_AUTO_COOL_OFF: assert property (s_eval ##0 (mode_in == MODE_MIXED_AUTO &&
      temp_in < limits_in.cool_set) |=> basic_cmd_out.cool == $past(invert_in))
    else $error("cooling not off below setpoint");
  AST_AUTO_DEAD: assert property (s_eval ##0 s_auto_dead |=>
      basic_cmd_out.heat == $past(invert_in) && basic_cmd_out.cool == $past(invert_in))
    else $error("request inside deadband");

  // Object-controlled mixed mode
  AST_OBJ_HEAT_OFF: assert property (s_eval ##0 (mode_in == MODE_MIXED_OBJ &&
      !cool_sel_in && temp_in > limits_in.heat_hi) |=> basic_cmd_out.heat == $past(invert_in))
    else $error("object heating not off above upper limit");
  AST_OBJ_COOL_OFF: assert property (s_eval ##0 (mode_in == MODE_MIXED_OBJ &&
      cool_sel_in && temp_in < limits_in.cool_lo) |=> basic_cmd_out.cool == $past(invert_in))
    else $error("object cooling not off below lower limit");
  AST_OBJ_SPAN: assert property (s_eval ##0 s_obj_heat_span |=> $stable(state[0].heat))
    else $error("object heating changed inside its span");

  // Message flags, no hysteresis, steady between evaluations
  AST_MSG_HEAT: assert property (s_eval ##0 mode_in == MODE_HEAT_ONLY |=>
      heat_msg_out == ($past(temp_in) < $past(limits_in.heat_set)))
    else $error("heating message wrong");
  AST_MSG_COOL: assert property (s_eval ##0 mode_in == MODE_COOL_ONLY |=>
      cool_msg_out == ($past(temp_in) > $past(limits_in.cool_set)))
    else $error("cooling message wrong");
  AST_MSG_STEADY: assert property (s_quiet |=> $stable(heat_msg_out) && $stable(cool_msg_out))
    else $error("message changed outside evaluation");

endmodule // two_point_hysteresis_control
`default_nettype wire

// *** dv/valve_actuator.sv ***
`timescale 1ns/1ps
`default_nettype none
// Switch actuator driving the heating and cooling valves
module valve_actuator
  import two_point_pkg::*;
(
  input wire stage_t cmd_in, // Command bits from controller
  input wire logic invert_in, // Actuator set for inverted commands
  output var stage_t open_out // Valve open state
);
  // undo inversion
  // A mismatched invert setting would run the valves backwards
  assign open_out = cmd_in ^ {2{invert_in}};
endmodule // valve_actuator
`default_nettype wire

// *** dv/two_point_hysteresis_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module two_point_hysteresis_control_tb;
  import two_point_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic signed [TEMP_W-1:0] temp_in = 16'h0898;
  op_mode_t mode_in = MODE_HEAT_ONLY;
  logic cool_sel_in = 1'b0;
  logic invert_in = 1'b0;
  // Set 2000/2400, heat band 1900-2100, cool band 2300-2500
  limits_t limits_in = {16'h07d0, 16'h0960, 16'h076c, 16'h0834, 16'h08fc, 16'h09c4};
  logic signed [TEMP_W-1:0] stage_offset_in = 16'h0064;
  stage_t basic_cmd_out, extra_cmd_out, valve;
  logic heat_msg_out, cool_msg_out, eval_tick_out;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  logic started = 1'b0;
  wire logic [5:0] outs = {basic_cmd_out, extra_cmd_out, heat_msg_out, cool_msg_out};

  always #25 clk_in = ~clk_in;

  // Short evaluation period keeps the run brief
  two_point_hysteresis_control #(.EVAL_CYCLES_P(8)) DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in), .temp_in(temp_in), .mode_in(mode_in), .cool_sel_in(cool_sel_in),
    .limits_in(limits_in), .stage_offset_in(stage_offset_in), .invert_in(invert_in),
    .basic_cmd_out(basic_cmd_out), .extra_cmd_out(extra_cmd_out), .heat_msg_out(heat_msg_out),
    .cool_msg_out(cool_msg_out), .eval_tick_out(eval_tick_out));
  valve_actuator partner (.cmd_in(basic_cmd_out), .invert_in(invert_in), .open_out(valve));

  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("Checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // Apply a temperature, then judge the next evaluation
  // e holds logical {basic, extra, heat msg, cool msg}
  task automatic ev(input logic [15:0] t, input logic [5:0] e);
    logic [5:0] prev;
    int n;
    temp_in = t;
    prev = outs;
    n = 0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
      if (eval_tick_out !== 1'b1)
        chk(outs === prev, "output moved between evaluations");
    end while (eval_tick_out !== 1'b1 && n < 20);
    chk(n == 8 || !started, "evaluation spacing");
    started = 1'b1;
    chk(outs === {e[5:2] ^ {4{invert_in}}, e[1:0]}, "command or message mismatch");
    chk(valve === e[5:4], "valve state mismatch");
  endtask

  task automatic heat_only();
    mode_in = MODE_HEAT_ONLY;
    ev(16'h079e, 6'h02);
    ev(16'h073a, 6'h22);
    ev(16'h0802, 6'h20);
    ev(16'h06d6, 6'h2a);
    ev(16'h0802, 6'h20);
    ev(16'h0866, 6'h00);
  endtask

  task automatic cool_only();
    mode_in = MODE_COOL_ONLY;
    ev(16'h0992, 6'h01);
    ev(16'h09f6, 6'h11);
    ev(16'h0a5a, 6'h15);
    ev(16'h092e, 6'h10);
    ev(16'h08ca, 6'h00);
  endtask

  task automatic mixed_auto();
    mode_in = MODE_MIXED_AUTO;
    ev(16'h073a, 6'h22);
    ev(16'h0802, 6'h00);
    ev(16'h0898, 6'h00);
    ev(16'h09f6, 6'h11);
    ev(16'h092e, 6'h00);
  endtask

  task automatic mixed_obj();
    mode_in = MODE_MIXED_OBJ;
    cool_sel_in = 1'b0;
    ev(16'h073a, 6'h22);
    ev(16'h0802, 6'h20);
    ev(16'h0866, 6'h00);
    cool_sel_in = 1'b1;
    ev(16'h09f6, 6'h11);
    ev(16'h092e, 6'h10);
    ev(16'h08ca, 6'h00);
  endtask

  task automatic inverted();
    invert_in = 1'b1;
    ev(16'h08ca, 6'h00);
    ev(16'h09f6, 6'h11);
    invert_in = 1'b0;
  endtask

  // Disabled clock must hold the evaluation back
  task automatic frozen();
    mode_in = MODE_HEAT_ONLY;
    ev(16'h0866, 6'h00);
    // Let the pulse end first; a disabled clock would hold it high
    @(posedge clk_in);
    #1;
    chk(eval_tick_out === 1'b0, "evaluation pulse longer than one cycle");
    clk_en_in = 1'b0;
    temp_in = 16'h073a;
    repeat (20) begin
      @(posedge clk_in);
      #1;
      chk(eval_tick_out === 1'b0 && outs === 6'h00, "change while disabled");
    end
    clk_en_in = 1'b1;
    started = 1'b0;
    ev(16'h073a, 6'h22);
  endtask

  // Cut a hang short
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    repeat (10) @(posedge clk_in);
    #1;
    sys_rst_in = 1'b0;
    chk(outs === 6'h00, "reset state");
    heat_only();
    cool_only();
    mixed_auto();
    mixed_obj();
    inverted();
    frozen();
    final_report();
  end
endmodule // two_point_hysteresis_control_tb
`default_nettype wire
